//--- fan_ctrl_defs.vh
`ifndef FAN_CTRL_DEFS_VH
`define FAN_CTRL_DEFS_VH

// Command-byte register offsets.
`define OFS_TARGET     8'h00
`define OFS_CONFIG     8'h02
`define OFS_PINDEF     8'h04
`define OFS_DAC        8'h06
`define OFS_ALARM_EN   8'h08
`define OFS_ALARM_STAT 8'h0a
`define OFS_PIN_STAT   8'h14

// Reset values.
`define RST_TARGET     8'h00
`define RST_CONFIG     8'h0a
`define RST_PINDEF     8'hff
`define RST_DAC        8'h00
`define RST_ALARM_EN   5'h00

// Configuration fields.
`define CFG_MODE_HI    5
`define CFG_MODE_LO    4
`define CFG_VSEL       3
`define CFG_SCALE_HI   2
`define CFG_SCALE_LO   0

// Operating modes.
`define MODE_FULL      2'h0
`define MODE_OFF       2'h1
`define MODE_CLOSED    2'h2
`define MODE_OPEN      2'h3

// Alarm bit positions.
`define ALM_MAX        0
`define ALM_MIN        1
`define ALM_OVF        2
`define ALM_PIN1       3
`define ALM_PIN2       4

// Drive levels: a higher level lowers the voltage across the fan.
`define DRIVE_FULL     8'h00
`define DRIVE_OFF      8'hff

// Regulator timing.
`define PERIOD_UNIT    128
`define REF_CLK_KHZ    250000
`define OSC_KHZ        254
`define MIN_PERIOD_US  1000

`endif

//--- fan_mode_gpio_alarm_ctrl.v
`timescale 1ns/100ps
`include "fan_ctrl_defs.vh"
// Contract
// - Config bits 5:4 pick full-speed 00, shutdown 01, closed 10, open 11.
// - Config bit 3 selects 5V (0) or 12V (1) fan class, reset 1.
// - Config bits 2:0 set prescaler 1,2,4,8,16; reset code 010.
// - Closed loop never targets a overflow_alarm_a period shorter than 1ms.
// - Target codes above F8h are accepted and simply lengthen the period.
// - External oscillator replaces internal clock as regulation reference.
// - Closed loop adjusts drive until overflow_alarm_a period matches the target.
// - Open loop applies the host-written 8-bit DAC value as drive.
// - Full-speed mode applies maximum drive regardless of registers.
// - Pin 1 as full-speed input driven low forces maximum drive.
// - Pins are open-drain; released level shows in pin status register.
// - Pin definition resets to all ones, every pull-down off.
// - Definition bits 7 and 6 drive pins 4 and 3 low or release.
// - Bits 5:4 set pin 2: clock in, clock out, low, release.
// - Bits 3:2 set pin 1: release, full-speed input, low, release.
// - Bits 1:0 set pin 0: release, alert output, low, release.
// - Pin 0 as alert pulls low while any enabled alarm is latched.
// - Only alarms whose enable bit is set latch status or alert.
// - Max and min drive alarms act only in closed-loop mode.
// - Status shows alarm causes; reading it clears bits and alert.
// - A status read clears a bit only if its condition is gone.
// - Target period is (code+1)*128 over prescaler times clock frequency.
// - Alarm bits: 4 pin2, 3 pin1 low, 2 overflow, 1 min, 0 max.
module fan_mode_gpio_alarm_ctrl #(
	parameter OSC_DIV   = (`REF_CLK_KHZ + `OSC_KHZ / 2) / `OSC_KHZ,
	parameter MIN_TICKS = (`OSC_KHZ * `MIN_PERIOD_US) / 1000
) (
	// Clock and reset.
	input  wire       ref_clk,
	input  wire       rstn,
	// Register port behind the serial slave.
	input  wire [7:0] regAddr,
	input  wire       regWrite,
	input  wire [7:0] regWdata,
	input  wire       regRead,
	output reg  [7:0] regRdata,
	// Fan side.
	input  wire       tachIn,
	input  wire       tachOverflow,
	output reg  [7:0] fanDrive,
	output wire       fanVoltageSel,
	// General-purpose open-drain pins, bit n is pin n.
	input  wire [4:0] gpIn,
	output wire [4:0] gpOut,
	output reg  [4:0] gpOe
);

	// Host-visible registers.
	reg [7:0]  targetPeriodCode;
	reg [7:0]  fanConfiguration;
	reg [7:0]  pinDefinition;
	reg [7:0]  dacValue;
	reg [4:0]  alarmEnable;
	reg [4:0]  alarmStatus;

	// Synchronisers and edge history for the asynchronous inputs.
	reg [4:0]  pinMeta;
	reg [4:0]  pinSync;
	reg        tachMeta;
	reg        tachSync;
	reg        tachLast;
	reg        oscLast;

	// Regulator state and combinational results.
	reg [15:0] divCount;
	reg [16:0] periodCount;
	reg [7:0]  loopDrive;
	reg [7:0]  next_fanDrive;
	reg [4:0]  alarmCond;
	reg [16:0] targetUnits;
	reg        oscTick;

	wire [1:0] mode = fanConfiguration[`CFG_MODE_HI:`CFG_MODE_LO];
	wire [1:0] pin2Cfg = pinDefinition[5:4];
	wire [1:0] pin1Cfg = pinDefinition[3:2];
	wire [1:0] pin0Cfg = pinDefinition[1:0];
	wire       extClock = (pin2Cfg == 2'b00);
	wire       fullForce = (pin1Cfg == 2'b01) && !pinSync[1];
	wire       tachEdge = tachSync && !tachLast;
	wire       intTick = (divCount == OSC_DIV[15:0] - 16'h0001);
	wire       extTick = pinSync[2] && !oscLast;
	wire       statRead = regRead && (regAddr == `OFS_ALARM_STAT);

	// Prescaler factor as a weight per oscillator tick.
	function [4:0] scaleWeight;
		input [2:0] code;
		begin
			case (code)
				3'h0:    scaleWeight = 5'h01;
				3'h1:    scaleWeight = 5'h02;
				3'h2:    scaleWeight = 5'h04;
				3'h3:    scaleWeight = 5'h08;
				default: scaleWeight = 5'h10;
			endcase
		end
	endfunction

	assign fanVoltageSel = fanConfiguration[`CFG_VSEL];
	assign gpOut = 5'h00;

	// Register writes; reset values leave every pull-down off.
	// Writes to read-only or unmapped offsets fall through and are ignored.
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			targetPeriodCode <= `RST_TARGET;
			fanConfiguration <= `RST_CONFIG;
			pinDefinition    <= `RST_PINDEF;
			dacValue         <= `RST_DAC;
			alarmEnable      <= `RST_ALARM_EN;
		end else if (regWrite) begin
			if (regAddr == `OFS_TARGET) begin
				targetPeriodCode <= regWdata;
			end else if (regAddr == `OFS_CONFIG) begin
				fanConfiguration <= {2'b00, regWdata[5:0]};
			end else if (regAddr == `OFS_PINDEF) begin
				pinDefinition <= regWdata;
			end else if (regAddr == `OFS_DAC) begin
				dacValue <= regWdata;
			end else if (regAddr == `OFS_ALARM_EN) begin
				alarmEnable <= regWdata[4:0];
			end
		end
	end

	// Read data is registered; unmapped offsets return zero.
	// A status read returns the bits as they stood before the read clears them.
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			regRdata <= 8'h00;
		end else if (regRead) begin
			if (regAddr == `OFS_TARGET) begin
				regRdata <= targetPeriodCode;
			end else if (regAddr == `OFS_CONFIG) begin
				regRdata <= fanConfiguration;
			end else if (regAddr == `OFS_PINDEF) begin
				regRdata <= pinDefinition;
			end else if (regAddr == `OFS_DAC) begin
				regRdata <= dacValue;
			end else if (regAddr == `OFS_ALARM_EN) begin
				regRdata <= {3'b000, alarmEnable};
			end else if (regAddr == `OFS_ALARM_STAT) begin
				regRdata <= {3'b000, alarmStatus};
			end else if (regAddr == `OFS_PIN_STAT) begin
				regRdata <= {3'b000, pinSync};
			end else begin
				regRdata <= 8'h00;
			end
		end
	end

	// Pins and tachometer arrive asynchronously and pass two flops first.
	// Pin status and every pin-driven function therefore lag the pins by
	// at least two cycles.
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pinMeta  <= 5'h1f;
			pinSync  <= 5'h1f;
			tachMeta <= 1'b0;
			tachSync <= 1'b0;
			tachLast <= 1'b0;
			oscLast  <= 1'b1;
		end else begin
			pinMeta  <= gpIn;
			pinSync  <= pinMeta;
			tachMeta <= tachIn;
			tachSync <= tachMeta;
			tachLast <= tachSync;
			oscLast  <= pinSync[2];
		end
	end

	// Internal oscillator emulated by dividing the reference clock.
	// Its rate is OSC_DIV reference cycles, so the nominal frequency holds
	// only to the rounding of that division.
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			divCount <= 16'h0000;
		end else if (intTick) begin
			divCount <= 16'h0000;
		end else begin
			divCount <= divCount + 16'h0001;
		end
	end

	always @* begin
		oscTick = extClock ? extTick : intTick;
		// Counting scale units per tick compares against (code+1)*128.
		targetUnits = {1'b0, ({8'h00, targetPeriodCode} + 16'h0001)
			<< 7};
		if (targetUnits < MIN_TICKS[16:0] *
				{12'h000, scaleWeight(fanConfiguration[2:0])}) begin
			targetUnits = MIN_TICKS[16:0] *
				{12'h000, scaleWeight(fanConfiguration[2:0])};
		end
	end

	// Closed loop: a period that ends early means too fast, so the drive
	// level rises, which lowers the fan voltage. A stalled fan saturates
	// the counter and is treated as too slow.
	// One step per overflow_alarm_a edge keeps the loop from overshooting, at the cost
	// of a sweep across the whole range taking 255 fan periods.
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			periodCount <= 17'h00000;
			loopDrive   <= `DRIVE_FULL;
		end else if (mode != `MODE_CLOSED) begin
			periodCount <= 17'h00000;
			loopDrive   <= `DRIVE_FULL;
		end else if (tachEdge || periodCount == 17'h1ffff) begin
			periodCount <= 17'h00000;
			if (tachEdge && periodCount < targetUnits) begin
				if (loopDrive != `DRIVE_OFF) begin
					loopDrive <= loopDrive + 8'h01;
				end
			end else if (periodCount > targetUnits) begin
				if (loopDrive != `DRIVE_FULL) begin
					loopDrive <= loopDrive - 8'h01;
				end
			end
		end else if (oscTick) begin
			if (periodCount > 17'h1ffff - 17'h00010) begin
				periodCount <= 17'h1ffff;
			end else begin
				periodCount <= periodCount +
					{12'h000, scaleWeight(fanConfiguration[2:0])};
			end
		end
	end

	// The hardware full-speed input outranks every software mode, so a hung
	// host cannot leave the fan stopped.
	always @* begin
		if (fullForce) begin
			next_fanDrive = `DRIVE_FULL;
		end else begin
			case (mode)
				`MODE_FULL:   next_fanDrive = `DRIVE_FULL;
				`MODE_OFF:    next_fanDrive = `DRIVE_OFF;
				`MODE_CLOSED: next_fanDrive = loopDrive;
				default:      next_fanDrive = dacValue;
			endcase
		end
	end

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			fanDrive <= `DRIVE_FULL;
		end else begin
			fanDrive <= next_fanDrive;
		end
	end

	// Alarm conditions, each gated by its enable.
	// The overflow condition comes from the overflow_alarm_a counter on this clock and
	// needs no synchroniser.
	always @* begin
		alarmCond = 5'h00;
		alarmCond[`ALM_MAX]  = (mode == `MODE_CLOSED) &&
			(loopDrive == `DRIVE_FULL);
		alarmCond[`ALM_MIN]  = (mode == `MODE_CLOSED) &&
			(loopDrive == `DRIVE_OFF);
		alarmCond[`ALM_OVF]  = tachOverflow;
		alarmCond[`ALM_PIN1] = !pinSync[1];
		alarmCond[`ALM_PIN2] = !pinSync[2];
		alarmCond = alarmCond & alarmEnable;
	end

	// A read clears only bits whose cause is gone; a new cause wins.
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			alarmStatus <= 5'h00;
		end else if (statRead) begin
			alarmStatus <= alarmStatus & alarmCond | alarmCond;
		end else begin
			alarmStatus <= alarmStatus | alarmCond;
		end
	end

	// Pull-down enables; the clock output holds low for half a period.
	// With an odd divider the clock output is low one cycle shorter than high.
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			gpOe <= 5'h00;
		end else begin
			gpOe[4] <= !pinDefinition[7];
			gpOe[3] <= !pinDefinition[6];
			case (pin2Cfg)
				2'b01:   gpOe[2] <= (divCount < OSC_DIV[15:0] >> 1);
				2'b10:   gpOe[2] <= 1'b1;
				default: gpOe[2] <= 1'b0;
			endcase
			gpOe[1] <= (pin1Cfg == 2'b10);
			case (pin0Cfg)
				2'b01:   gpOe[0] <= (alarmStatus != 5'h00);
				2'b10:   gpOe[0] <= 1'b1;
				default: gpOe[0] <= 1'b0;
			endcase
		end
	end

endmodule // fan_mode_gpio_alarm_ctrl

//--- fan_ctrl_asserts.sv
`timescale 1ns/100ps
`include "fan_ctrl_defs.vh"
module fan_ctrl_asserts (
	// Clock and reset.
	input wire       ref_clk,
	input wire       rstn,
	// Register port.
	input wire [7:0] regAddr,
	input wire       regWrite,
	input wire [7:0] regWdata,
	input wire       regRead,
	input wire [7:0] regRdata,
	// Fan side.
	input wire       tachIn,
	input wire       tachOverflow,
	input wire [7:0] fanDrive,
	input wire       fanVoltageSel,
	// Pins.
	input wire [4:0] gpIn,
	input wire [4:0] gpOut,
	input wire [4:0] gpOe
);
	logic [7:0] cfg;
	wire        cfgWr = regWrite && regAddr == `OFS_CONFIG;
	wire        pinWr = regWrite && regAddr == `OFS_PINDEF;
	always @(posedge ref_clk or negedge rstn)
		if (!rstn)
			cfg <= `RST_CONFIG;
		else if (cfgWr)
			cfg <= {2'b00, regWdata[5:0]};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_open_wire_low: assert property (gpOut == 5'h00)
		else $error("pin data output not zero");
	a_voltage_follows: assert property (cfgWr |=>
		fanVoltageSel == $past(regWdata[3])) else $error("voltage select");
	a_full_drive: assert property (cfgWr && regWdata[5:4] == `MODE_FULL
		|-> ##2 fanDrive == `DRIVE_FULL) else $error("full mode drive");
	a_off_drive: assert property (cfgWr && regWdata[5:4] == `MODE_OFF
		|-> ##2 fanDrive == `DRIVE_OFF) else $error("shutdown drive");
	a_open_dac: assert property (regWrite && regAddr == `OFS_DAC &&
		cfg[5:4] == `MODE_OPEN |-> ##2 fanDrive == $past(regWdata, 2))
		else $error("open loop drive");
	a_pin_low: assert property (pinWr |->
		##2 gpOe[4:3] == ~$past(regWdata[7:6], 2)) else $error("pin pull");
	a_cfg_readback: assert property (regRead && regAddr == `OFS_CONFIG
		|=> regRdata == $past(cfg)) else $error("config readback");
	a_stat_upper: assert property (regRead &&
		(regAddr == `OFS_PIN_STAT || regAddr == `OFS_ALARM_STAT) |=>
		regRdata[7:5] == 3'h0) else $error("status upper bits");
	c_loop_top: cover property (cfg[5:4] == `MODE_CLOSED && fanDrive == 8'hff);
	c_alert: cover property (gpOe[0]);
	c_stat_read: cover property (regRead && regAddr == `OFS_ALARM_STAT);
endmodule // fan_ctrl_asserts

//--- fan_overflow_alarm_a_model.sv
`timescale 1ns/100ps
module fan_overflow_alarm_a_model #(
	parameter HALF = 10
) (
	// Clock.
	input  wire  ref_clk,
	// Fan running.
	input  wire  spin,
	// Tachometer line.
	output logic tachIn
);
	int cnt = 0;
	initial tachIn = 1'b0;
	// A stopped fan parks its line low, so no stray edge reaches the loop.
	always @(posedge ref_clk) begin
		if (!spin) begin
			cnt <= 0;
			tachIn <= 1'b0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			tachIn <= ~tachIn;
		end else
			cnt <= cnt + 1;
	end
endmodule // fan_overflow_alarm_a_model

//--- tb.sv
`timescale 1ns/100ps
`include "fan_ctrl_defs.vh"
module tb;
	logic       ref_clk = 1'b0, rstn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, d, dac;
	logic       tachOverflow = 1'b0, spin = 1'b0, probe = 1'b0, rdTaken = 1'b0;
	logic [4:0] extLow = 5'h00;
	logic [31:0] seed = 32'h000100e8;
	wire  [7:0] regRdata, fanDrive;
	wire  [4:0] gpOut, gpOe, gpIn;
	wire        tachIn, fanVoltageSel;
	logic [7:0] expq[$];
	int         error_cnt = 0, comparisons = 0, i;
	// Pins float high unless the design or the outside world sinks them.
	assign gpIn = ~(gpOe | extLow);
	always #2 ref_clk = ~ref_clk;
	fan_mode_gpio_alarm_ctrl #(.OSC_DIV(8)) fan_mode_gpio_alarm_ctrl_inst (
		.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr),
		.regWrite(regWrite), .regWdata(regWdata), .regRead(regRead),
		.regRdata(regRdata), .tachIn(tachIn), .tachOverflow(tachOverflow),
		.fanDrive(fanDrive), .fanVoltageSel(fanVoltageSel), .gpIn(gpIn),
		.gpOut(gpOut), .gpOe(gpOe));
	fan_overflow_alarm_a_model fan_overflow_alarm_a_model_inst (
		.ref_clk(ref_clk), .spin(spin), .tachIn(tachIn));
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	task automatic tally_and_finish();
		$display("comparisons=%0d errors=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [7:0] got);
		logic [7:0] e;
		e = expq.pop_front();
		comparisons++;
		if (got !== e) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, got, e);
			error_cnt++;
		end
	endtask
	always @(posedge ref_clk) begin
		if (rdTaken)
			check(regRdata);
		if (probe)
			check(fanDrive);
		rdTaken <= regRead;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= v;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask
	// The waits cover pin synchronisers and the registered drive path.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expq.push_back(e);
		repeat (6) @(posedge ref_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
	endtask
	task automatic drv(input logic [7:0] e);
		expq.push_back(e);
		repeat (4) @(posedge ref_clk);
		probe <= 1'b1;
		@(posedge ref_clk);
		probe <= 1'b0;
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(`OFS_CONFIG, 8'h0a);
		rd(`OFS_PINDEF, 8'hff);
		rd(`OFS_PIN_STAT, 8'h1f);
		rd(`OFS_ALARM_EN, 8'h00);
		rd(8'h30, 8'h00);
		drv(8'h00);
		wr(`OFS_PINDEF, 8'h2b);
		rd(`OFS_PIN_STAT, 8'h01);
		wr(`OFS_PINDEF, 8'hfe);
		rd(`OFS_PIN_STAT, 8'h1e);
		wr(`OFS_PINDEF, 8'hff);
		rd(`OFS_PIN_STAT, 8'h1f);
		for (i = 0; i < 8; i++) begin
			dac = rnd();
			d = rnd();
			wr(`OFS_DAC, dac);
			wr(`OFS_TARGET, {5'h1f, d[6:4]});
			wr(`OFS_CONFIG, {d[7:6], i[1:0], d[3:0]});
			rd(`OFS_TARGET, {5'h1f, d[6:4]});
			rd(`OFS_DAC, dac);
			rd(`OFS_CONFIG, {2'b00, i[1:0], d[3:0]});
			if (i[1:0] != `MODE_CLOSED)
				drv(i[1:0] == 2'h0 ? 8'h00 : i[1:0] == 2'h1 ? 8'hff : dac);
		end
		wr(`OFS_ALARM_EN, 8'h02);
		wr(`OFS_PINDEF, 8'hfd);
		wr(`OFS_CONFIG, 8'h28);
		spin <= 1'b1;
		for (i = 0; i < 12000 && fanDrive !== 8'hff; i++)
			@(posedge ref_clk);
		if (i == 12000) begin
			error_cnt++;
			tally_and_finish();
		end
		drv(8'hff);
		rd(`OFS_ALARM_STAT, 8'h02);
		rd(`OFS_PIN_STAT, 8'h1e);
		rd(`OFS_ALARM_STAT, 8'h02);
		spin <= 1'b0;
		wr(`OFS_CONFIG, 8'h38);
		rd(`OFS_ALARM_STAT, 8'h02);
		rd(`OFS_ALARM_STAT, 8'h00);
		rd(`OFS_PIN_STAT, 8'h1f);
		tachOverflow <= 1'b1;
		rd(`OFS_ALARM_STAT, 8'h00);
		wr(`OFS_ALARM_EN, 8'h04);
		rd(`OFS_ALARM_STAT, 8'h04);
		tachOverflow <= 1'b0;
		wr(`OFS_DAC, 8'h55);
		drv(8'h55);
		wr(`OFS_PINDEF, 8'hf7);
		extLow <= 5'h02;
		drv(8'h00);
		extLow <= 5'h00;
		// Let the checker take the last note before the verdict.
		repeat (2) @(posedge ref_clk);
		if (expq.size() != 0)
			error_cnt++;
		tally_and_finish();
	end
endmodule // tb
bind fan_mode_gpio_alarm_ctrl fan_ctrl_asserts fan_ctrl_asserts_inst (
	.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr), .regWrite(regWrite),
	.regWdata(regWdata), .regRead(regRead), .regRdata(regRdata),
	.tachIn(tachIn), .tachOverflow(tachOverflow), .fanDrive(fanDrive),
	.fanVoltageSel(fanVoltageSel), .gpIn(gpIn), .gpOut(gpOut), .gpOe(gpOe));
